// file: common/mlsr_pkg.sv
// Purpose: constants for the monitor limit and status register bank
// Assumes: command codes arrive already decoded from the two-wire link
// Notes: limit slots are indexed 0..7 in the order of the code table below
package mlsr_pkg;

  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OUT_HIGH_V = 8'h42;
  localparam logic [7:0] CMD_OUT_LOW_V = 8'h43;
  localparam logic [7:0] CMD_OUT_CURRENT = 8'h4A;
  localparam logic [7:0] CMD_OVERHEAT_SHUT = 8'h4F;
  localparam logic [7:0] CMD_OVERHEAT_ALARM = 8'h51;
  localparam logic [7:0] CMD_IN_HIGH_V = 8'h57;
  localparam logic [7:0] CMD_IN_LOW_V = 8'h58;
  localparam logic [7:0] CMD_IN_POWER = 8'h6B;
  localparam logic [7:0] CMD_SUMMARY_STATUS = 8'h78;

  // limit slot indices, also warning flag bit positions
  localparam int LIM_COUNT = 8;
  localparam logic [2:0] IDX_OUT_HIGH_V = 3'h0;
  localparam logic [2:0] IDX_OUT_LOW_V = 3'h1;
  localparam logic [2:0] IDX_OUT_CURRENT = 3'h2;
  localparam logic [2:0] IDX_OVERHEAT_SHUT = 3'h3;
  localparam logic [2:0] IDX_OVERHEAT_ALARM = 3'h4;
  localparam logic [2:0] IDX_IN_HIGH_V = 3'h5;
  localparam logic [2:0] IDX_IN_LOW_V = 3'h6;
  localparam logic [2:0] IDX_IN_POWER = 3'h7;

  // reset values and writable masks
  localparam logic [15:0] RST_HIGH_LIMIT = 16'h0FFF;
  localparam logic [15:0] RST_LOW_LIMIT = 16'h0000;
  localparam logic [15:0] RST_POWER_LIMIT = 16'h7FFF;
  localparam logic [15:0] MASK_12BIT = 16'h0FFF;
  localparam logic [15:0] MASK_15BIT = 16'h7FFF;

  // summary status byte layout
  localparam logic [7:0] RST_SUMMARY = 8'h00;
  localparam int BIT_GATE_OFF = 6;
  localparam int BIT_OC_TRIP = 4;

  // request kinds on the command port
  typedef enum logic [1:0] {
    MLSR_REQ_NONE = 2'h0,
    MLSR_REQ_READ = 2'h1,
    MLSR_REQ_WRITE = 2'h3,
    MLSR_REQ_SEND = 2'h2
  } mlsr_req_t;

endpackage

// file: hw/mlsr_regs.sv
// Purpose: threshold registers, warning latches and summary status byte
// Assumes: one request per cycle at most; measurements share the clock
// Notes: gate and trip levels come from analog logic and are synchronised
// Function
// - output overvoltage limit, 12 bits, resets 0xFFF
// - output undervoltage limit, 12 bits, resets 0x000
// - output overcurrent limit, 12 bits, resets 0xFFF
// - overtemperature shutdown limit, 12 bits, resets 0xFFF
// - separate overtemperature alarm limit, resets 0xFFF
// - input overvoltage limit, 12 bits, resets 0xFFF
// - input undervoltage limit, 12 bits, resets 0x000
// - input power limit, 15 bits, resets 0x7FFF
// - upper four bits of 12-bit limits read zero
// - status byte resets zero, low byte of word
// - status bit one means condition occurred
// - bit 6 live gate-off flag, read only
// - gate-off flag follows only the synchronised gate drive off level
// - bit 4 latched overcurrent trip until cleared
// - clear-faults clears flags except still-active ones
// - turn-on clears flags no longer active
`timescale 1ns/100ps
module mlsr_regs import mlsr_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // command port
  input wire mlsr_req_t req_kind,
  input wire logic [7:0] req_code,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [15:0] rsp_rdata,
  // turn-on request from the operation control
  input wire logic output_on_pulse,
  // measurements from the converter sequencer
  input wire logic meas_valid,
  input wire logic [11:0] output_sense_meas,
  input wire logic [11:0] supply_sense_meas,
  input wire logic [11:0] current_meas,
  input wire logic [11:0] temp_meas,
  input wire logic [14:0] power_meas,
  // analog levels, asynchronous
  input wire logic gate_drive_off_in,
  input wire logic overcurrent_trip_in,
  // status out
  output logic [7:0] summary_status_low,
  output logic [7:0] warn_flags
);

  logic [15:0] lim_reg [LIM_COUNT];
  logic [15:0] lim_next [LIM_COUNT];
  logic [7:0] warn_reg, warn_next;
  logic [7:0] active_reg, active_next;
  logic [7:0] status_reg, status_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic rsp_error_reg, rsp_error_next;
  logic [15:0] rsp_rdata_reg, rsp_rdata_next;
  logic gate_s1_reg, gate_s2_reg, trip_s1_reg, trip_s2_reg;
  logic hit;
  logic [2:0] idx;
  logic clear_cmd, clear_any;
  logic [7:0] over;

  function automatic logic [15:0] lim_reset(input logic [2:0] i);
    case (i)
      IDX_OUT_LOW_V, IDX_IN_LOW_V: lim_reset = RST_LOW_LIMIT;
      IDX_IN_POWER: lim_reset = RST_POWER_LIMIT;
      default: lim_reset = RST_HIGH_LIMIT;
    endcase
  endfunction

  // code decode into a limit slot
  always_comb begin
    hit = 1'b1;
    idx = IDX_OUT_HIGH_V;
    case (req_code)
      CMD_OUT_HIGH_V: idx = IDX_OUT_HIGH_V;
      CMD_OUT_LOW_V: idx = IDX_OUT_LOW_V;
      CMD_OUT_CURRENT: idx = IDX_OUT_CURRENT;
      CMD_OVERHEAT_SHUT: idx = IDX_OVERHEAT_SHUT;
      CMD_OVERHEAT_ALARM: idx = IDX_OVERHEAT_ALARM;
      CMD_IN_HIGH_V: idx = IDX_IN_HIGH_V;
      CMD_IN_LOW_V: idx = IDX_IN_LOW_V;
      CMD_IN_POWER: idx = IDX_IN_POWER;
      default: hit = 1'b0;
    endcase
  end

  // two-stage synchronisers for the analog levels
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gate_s1_reg <= 1'b0;
      gate_s2_reg <= 1'b0;
      trip_s1_reg <= 1'b0;
      trip_s2_reg <= 1'b0;
    end else begin
      gate_s1_reg <= gate_drive_off_in;
      gate_s2_reg <= gate_s1_reg;
      trip_s1_reg <= overcurrent_trip_in;
      trip_s2_reg <= trip_s1_reg;
    end
  end

  // limit storage
  always_comb begin
    for (int i = 0; i < LIM_COUNT; i++) begin
      lim_next[i] = lim_reg[i];
    end
    if (req_kind == MLSR_REQ_WRITE && hit) begin
      if (idx == IDX_IN_POWER) begin
        lim_next[idx] = req_wdata & MASK_15BIT;
      end else begin
        lim_next[idx] = req_wdata & MASK_12BIT;
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < LIM_COUNT; i++) begin
      if (!rst_b) begin
        lim_reg[i] <= lim_reset(3'(i));
      end else begin
        lim_reg[i] <= lim_next[i];
      end
    end
  end

  // comparisons against the stored thresholds
  always_comb begin
    over[IDX_OUT_HIGH_V] = output_sense_meas > lim_reg[IDX_OUT_HIGH_V][11:0];
    over[IDX_OUT_LOW_V] = output_sense_meas < lim_reg[IDX_OUT_LOW_V][11:0];
    over[IDX_OUT_CURRENT] = current_meas > lim_reg[IDX_OUT_CURRENT][11:0];
    over[IDX_OVERHEAT_SHUT] = temp_meas > lim_reg[IDX_OVERHEAT_SHUT][11:0];
    over[IDX_OVERHEAT_ALARM] = temp_meas > lim_reg[IDX_OVERHEAT_ALARM][11:0];
    over[IDX_IN_HIGH_V] = supply_sense_meas > lim_reg[IDX_IN_HIGH_V][11:0];
    over[IDX_IN_LOW_V] = supply_sense_meas < lim_reg[IDX_IN_LOW_V][11:0];
    over[IDX_IN_POWER] = power_meas > lim_reg[IDX_IN_POWER][14:0];
  end

  assign clear_cmd = (req_kind == MLSR_REQ_SEND) && (req_code == CMD_CLEAR_FAULTS);
  assign clear_any = clear_cmd || output_on_pulse;

  // warning latches: a fresh crossing wins over a clear in the same cycle
  always_comb begin
    active_next = meas_valid ? over : active_reg;
    warn_next = warn_reg;
    if (clear_any) begin
      warn_next = warn_reg & active_reg;
    end
    if (meas_valid) begin
      warn_next = warn_next | over;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      active_reg <= 8'h00;
      warn_reg <= 8'h00;
    end else begin
      active_reg <= active_next;
      warn_reg <= warn_next;
    end
  end

  // summary status byte
  always_comb begin
    status_next = RST_SUMMARY;
    status_next[BIT_GATE_OFF] = gate_s2_reg;
    // trip level still present keeps the bit set across any clear
    status_next[BIT_OC_TRIP] = trip_s2_reg |
      (status_reg[BIT_OC_TRIP] & ~clear_any);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_reg <= RST_SUMMARY;
    end else begin
      status_reg <= status_next;
    end
  end

  // command answers, one cycle after the request
  always_comb begin
    rsp_valid_next = req_kind != MLSR_REQ_NONE;
    rsp_error_next = 1'b0;
    rsp_rdata_next = 16'h0000;
    case (req_kind)
      MLSR_REQ_READ: begin
        if (hit) begin
          rsp_rdata_next = lim_reg[idx];
        end else if (req_code == CMD_SUMMARY_STATUS) begin
          rsp_rdata_next = {8'h00, status_reg};
        end else begin
          rsp_error_next = 1'b1;
        end
      end
      MLSR_REQ_WRITE: rsp_error_next = !hit;
      MLSR_REQ_SEND: rsp_error_next = !clear_cmd;
      default: rsp_error_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rsp_valid_reg <= 1'b0;
      rsp_error_reg <= 1'b0;
      rsp_rdata_reg <= 16'h0000;
    end else begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_error_reg <= rsp_error_next;
      rsp_rdata_reg <= rsp_rdata_next;
    end
  end

  assign rsp_valid = rsp_valid_reg;
  assign rsp_error = rsp_error_reg;
  assign rsp_rdata = rsp_rdata_reg;
  assign summary_status_low = status_reg;
  assign warn_flags = warn_reg;

  // checks
  sequence ov_write_s;
    req_kind == MLSR_REQ_WRITE && req_code == CMD_OUT_HIGH_V;
  endsequence

  sequence ov_read_s;
    req_kind == MLSR_REQ_READ && req_code == CMD_OUT_HIGH_V;
  endsequence

  ov_roundtrip_a: assert property (@(posedge clk) disable iff (!rst_b)
    ov_write_s ##1 ov_read_s |=> rsp_rdata == {4'h0, $past(req_wdata[11:0], 2)})
    else $error("output high limit readback wrong");

  lim_upper_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_kind == MLSR_REQ_READ && hit && idx != IDX_IN_POWER |=> rsp_rdata[15:12] == 4'h0)
    else $error("12-bit limit upper bits not zero");

  power_top_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_kind == MLSR_REQ_READ && req_code == CMD_IN_POWER |=> !rsp_rdata[15])
    else $error("power limit bit 15 not zero");

  gate_live_a: assert property (@(posedge clk) disable iff (!rst_b)
    gate_s2_reg |=> status_reg[BIT_GATE_OFF] ##1 (status_reg[BIT_GATE_OFF] == $past(gate_s2_reg)))
    else $error("gate-off flag not following level");

  oc_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    status_reg[BIT_OC_TRIP] && !clear_any |=> status_reg[BIT_OC_TRIP])
    else $error("overcurrent flag dropped without clear");

  oc_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    clear_cmd && !trip_s2_reg |=> !status_reg[BIT_OC_TRIP])
    else $error("overcurrent flag not cleared");

  oc_active_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    clear_cmd && trip_s2_reg |=> status_reg[BIT_OC_TRIP])
    else $error("active overcurrent flag was cleared");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    status_reg[7] == 1'b0 && status_reg[5] == 1'b0 && status_reg[3:0] == 4'h0)
    else $error("reserved status bits set");

  ov_warn_a: assert property (@(posedge clk) disable iff (!rst_b)
    meas_valid && output_sense_meas > lim_reg[IDX_OUT_HIGH_V][11:0]
    |=> warn_flags[IDX_OUT_HIGH_V] [*2] or (warn_flags[IDX_OUT_HIGH_V] ##1 clear_any))
    else $error("overvoltage warning not raised");

  turn_on_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    output_on_pulse && !meas_valid && !active_reg[IDX_OUT_LOW_V] |=> !warn_flags[IDX_OUT_LOW_V])
    else $error("inactive warning survived turn-on");

  status_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_kind == MLSR_REQ_READ && req_code == CMD_SUMMARY_STATUS
    |=> rsp_valid && rsp_rdata == {8'h00, $past(status_reg)})
    else $error("status byte read wrong");

  ro_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_kind == MLSR_REQ_WRITE && req_code == CMD_SUMMARY_STATUS |=> rsp_error)
    else $error("write to status byte not refused");

endmodule // mlsr_regs

// file: tb/mlsr_host.sv
// Purpose: host side of the command port, one word per request
// Assumes: every call starts just after a rising edge of clk
// Notes: released code and data lines show the inverse of the last value, never a stale copy; the kind returns to none
`timescale 1ns/100ps
module mlsr_host import mlsr_pkg::*; (
  // clock
  input wire logic clk,
  // answer from the bank
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic [15:0] rsp_rdata,
  // request to the bank
  output mlsr_req_t req_kind,
  output logic [7:0] req_code,
  output logic [15:0] req_wdata
);
  initial begin
    req_kind = MLSR_REQ_NONE;
    req_code = 8'h00;
    req_wdata = 16'h0000;
  end

  // a send carries no data word; the answer is taken one edge after the request
  // keep leaves the request up for a back-to-back follower, so no line is set twice at once
  task automatic xfer(input mlsr_req_t k, input logic [7:0] c, input logic [15:0] d,
                      input bit keep,
                      output logic ok, output logic err, output logic [15:0] q);
    req_kind = k;
    req_code = c;
    req_wdata = d;
    @(posedge clk);
    #1;
    ok = (rsp_valid === 1'b1);
    err = rsp_error;
    q = rsp_rdata;
    if (!keep) begin
      req_kind = MLSR_REQ_NONE;
      req_code = ~c;
      req_wdata = ~d;
      @(posedge clk);
      #1;
    end
  endtask
endmodule // mlsr_host

// file: tb/mlsr_regs_test.sv
// Purpose: self-checking bench for the limit and status register bank
// Assumes: inputs change 1 ns after the rising edge
// Notes: flags are checked one edge after a measure or turn-on, two after a clear; status three edges after a level change, two after a clear
`timescale 1ns/100ps
module mlsr_regs_test import mlsr_pkg::*; ;
  logic clk, rst_b, rsp_valid, rsp_error, output_on_pulse, meas_valid;
  logic gate_drive_off_in, overcurrent_trip_in;
  mlsr_req_t req_kind;
  logic [7:0] req_code, summary_status_low, warn_flags;
  logic [15:0] req_wdata, rsp_rdata;
  logic [11:0] output_sense_meas, supply_sense_meas, current_meas, temp_meas;
  logic [14:0] power_meas;
  int mismatches = 0;
  int checks_done = 0;
  localparam logic [7:0] CODES [8] = '{CMD_OUT_HIGH_V, CMD_OUT_LOW_V, CMD_OUT_CURRENT,
    CMD_OVERHEAT_SHUT, CMD_OVERHEAT_ALARM, CMD_IN_HIGH_V, CMD_IN_LOW_V, CMD_IN_POWER};
  localparam logic [15:0] RSTV [8] = '{16'h0FFF, 16'h0000, 16'h0FFF, 16'h0FFF,
    16'h0FFF, 16'h0FFF, 16'h0000, 16'h7FFF};

  mlsr_host mlsr_host_i (.clk(clk), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_rdata(rsp_rdata), .req_kind(req_kind), .req_code(req_code), .req_wdata(req_wdata));

  mlsr_regs mlsr_regs_i (.clk(clk), .rst_b(rst_b), .req_kind(req_kind), .req_code(req_code),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_rdata(rsp_rdata), .output_on_pulse(output_on_pulse), .meas_valid(meas_valid),
    .output_sense_meas(output_sense_meas), .supply_sense_meas(supply_sense_meas),
    .current_meas(current_meas), .temp_meas(temp_meas), .power_meas(power_meas),
    .gate_drive_off_in(gate_drive_off_in), .overcurrent_trip_in(overcurrent_trip_in),
    .summary_status_low(summary_status_low), .warn_flags(warn_flags));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic acc(input mlsr_req_t k, input logic [7:0] c, input logic [15:0] d,
                     input logic e_exp, input logic [15:0] q_exp, input bit keep = 1'b0);
    logic ok;
    logic err;
    logic [15:0] q;
    mlsr_host_i.xfer(k, c, d, keep, ok, err, q);
    check("answer", {15'h0, ok}, 16'h0001);
    check("error", {15'h0, err}, {15'h0, e_exp});
    check("rdata", q, q_exp);
  endtask

  // voltage and temperature measurements take one value, current its own, power follows the first
  task automatic measure(input logic [11:0] v, input logic [11:0] cu, input logic [7:0] f_exp);
    output_sense_meas = v;
    supply_sense_meas = v;
    temp_meas = v;
    current_meas = cu;
    power_meas = {3'h0, v};
    meas_valid = 1'b1;
    @(posedge clk);
    #1;
    meas_valid = 1'b0;
    check("warn_flags", {8'h00, warn_flags}, {8'h00, f_exp});
  endtask

  task automatic settle_status(input logic [7:0] exp);
    repeat (3) @(posedge clk);
    #1;
    check("status", {8'h00, summary_status_low}, {8'h00, exp});
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #25000;
    mismatches++;
    end_sim();
  end

  initial begin
    rst_b = 1'b0;
    {output_on_pulse, meas_valid, gate_drive_off_in, overcurrent_trip_in} = 4'h0;
    {output_sense_meas, supply_sense_meas, current_meas, temp_meas} = 48'h0;
    power_meas = 15'h0000;
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 8; i++) acc(MLSR_REQ_READ, CODES[i], 16'h0000, 1'b0, RSTV[i]);
    acc(MLSR_REQ_READ, CMD_SUMMARY_STATUS, 16'h0000, 1'b0, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      acc(MLSR_REQ_WRITE, CODES[i], 16'hFFFF, 1'b0, 16'h0000, 1'b1);
      acc(MLSR_REQ_READ, CODES[i], 16'h0000, 1'b0, (i == 7) ? 16'h7FFF : 16'h0FFF);
    end
    acc(MLSR_REQ_WRITE, CMD_SUMMARY_STATUS, 16'hFFFF, 1'b1, 16'h0000);
    acc(MLSR_REQ_READ, CMD_SUMMARY_STATUS, 16'h0000, 1'b0, 16'h0000);
    acc(MLSR_REQ_READ, 8'h10, 16'h0000, 1'b1, 16'h0000);
    acc(MLSR_REQ_SEND, 8'h05, 16'h0000, 1'b1, 16'h0000);
    measure(12'h800, 12'h800, 8'h42);
    acc(MLSR_REQ_WRITE, CMD_OUT_LOW_V, 16'h0000, 1'b0, 16'h0000);
    acc(MLSR_REQ_WRITE, CMD_IN_LOW_V, 16'h0000, 1'b0, 16'h0000);
    acc(MLSR_REQ_WRITE, CMD_OUT_CURRENT, 16'h07FF, 1'b0, 16'h0000);
    // every over-limit slot below the test level, so each warning bit is reached
    acc(MLSR_REQ_WRITE, CMD_OUT_HIGH_V, 16'h07FF, 1'b0, 16'h0000);
    acc(MLSR_REQ_WRITE, CMD_OVERHEAT_SHUT, 16'h07FF, 1'b0, 16'h0000);
    acc(MLSR_REQ_WRITE, CMD_OVERHEAT_ALARM, 16'h07FF, 1'b0, 16'h0000);
    acc(MLSR_REQ_WRITE, CMD_IN_HIGH_V, 16'h07FF, 1'b0, 16'h0000);
    acc(MLSR_REQ_WRITE, CMD_IN_POWER, 16'h07FF, 1'b0, 16'h0000);
    measure(12'h800, 12'h800, 8'hFF);
    acc(MLSR_REQ_SEND, CMD_CLEAR_FAULTS, 16'h0000, 1'b0, 16'h0000);
    check("warn_flags", {8'h00, warn_flags}, 16'h00BD);
    measure(12'h100, 12'h100, 8'hBD);
    output_on_pulse = 1'b1;
    @(posedge clk);
    #1;
    output_on_pulse = 1'b0;
    check("warn_flags", {8'h00, warn_flags}, 16'h0000);
    overcurrent_trip_in = 1'b1;
    gate_drive_off_in = 1'b1;
    settle_status(8'h50);
    acc(MLSR_REQ_READ, CMD_SUMMARY_STATUS, 16'h0000, 1'b0, 16'h0050);
    overcurrent_trip_in = 1'b0;
    gate_drive_off_in = 1'b0;
    settle_status(8'h10);
    acc(MLSR_REQ_SEND, CMD_CLEAR_FAULTS, 16'h0000, 1'b0, 16'h0000);
    check("status", {8'h00, summary_status_low}, 16'h0000);
    end_sim();
  end
endmodule // mlsr_regs_test
